// ===== pkg/gdc_pkg.sv
/*
 * Constants and carrier types for the gamma-select and display-enable
 * command decoder of the panel driver's host interface.
 * Assumes a single 10 MHz system clock and a host bus that is
 * asynchronous to it, sampled through three-stage synchronisers.
 */
// Summary of operation
// - gamma select opcode 26h is a command cycle; next data cycle is its parameter
// - parameter taken with select high and read strobe high; upper byte ignored
// - parameter is one-hot: 01h, 02h, 04h, 08h pick curves one to four
// - at most four fixed curves, exactly one active at all times
// - any other parameter value is invalid; previous curve is kept
// - every reset restores the curve-one code 01h
// - display-off opcode 28h blanks the panel instead of showing frame memory
// - display-off is a command cycle with no parameter
// - display on/off touch nothing else: no memory or mode change; both still drop a pending gamma parameter
// - blanking switches without visible artefact
// - display-off while already off does nothing
// - display-on opcode 29h routes frame memory to the panel again
// - display-on while already on does nothing
// - every reset starts with the display output disabled
// - all three commands are accepted in every operating state
package gdc_pkg;

    // ------------------------------------------------------------------
    // opcodes and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0] GAMMA_CURVE_SELECT_CMD      = 8'h26;
    localparam logic [7:0] DISPLAY_OUTPUT_DISABLE_CMD  = 8'h28;
    localparam logic [7:0] DISPLAY_OUTPUT_ENABLE_CMD   = 8'h29;
    localparam int         BUS_WIDTH                   = 16;
    localparam int         PARAM_LSB                   = 0;
    localparam int         PARAM_MSB                   = 7;

    // ------------------------------------------------------------------
    // curve codes and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CURVE1_BIT        = 8'h01;
    localparam logic [7:0] CURVE2_BIT        = 8'h02;
    localparam logic [7:0] CURVE3_BIT        = 8'h04;
    localparam logic [7:0] CURVE4_BIT        = 8'h08;
    localparam logic [7:0] CURVE_SELECT_RST  = CURVE1_BIT;
    localparam logic       DISPLAY_EN_RST    = 1'b0;
    localparam logic       STROBE_IDLE_RST   = 1'b1;
    localparam logic       SELECT_RST        = 1'b1;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                 dataCommandSelect;
        logic                 readStrobeN;
        logic [BUS_WIDTH-1:0] data;
    } gdc_bus_t;

    typedef struct packed {
        logic       displayEnable;
        logic [1:0] curveIndex;
        logic [7:0] curveSelectParam;
    } gdc_out_t;

    typedef enum logic {
        GDC_IDLE,
        GDC_WAIT_PARAM
    } gdc_state_t;

endpackage

// ===== verilog/gdc_cmd_decoder.sv
/*
 * Command decoder for gamma curve select, display output disable and
 * display output enable. Holds the active curve and display state.
 * Assumes host strobes and data are asynchronous; data must stay put
 * for at least four system clocks after the write strobe rises.
 * frameStart is a one-cycle pulse from panel timing on sys_clk.
 */
`timescale 1ns/1ps
module gdc_cmd_decoder (
    // clock and reset
    input  logic              sys_clk,
    input  logic              rstn,
    // host bus pins
    input  logic              writeStrobeN,
    input  gdc_pkg::gdc_bus_t hostBus,
    // same-domain controls
    input  logic              softReset,
    input  logic              frameStart,
    // downstream gamma and panel-output logic
    output gdc_pkg::gdc_out_t panelCtrl
);
    import gdc_pkg::*;

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0] rstPipe_r;
    logic       rstSyncN;

    // async assert, two-flop release
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstPipe_r <= 2'b00;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe_r[1];

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic     wrS1_r, wrS2_r, wrS3_r, wrLevel_r;
    logic     wrS1_nxt, wrS2_nxt, wrS3_nxt, wrLevel_nxt;
    gdc_bus_t busS1_r, busS2_r, busS3_r;
    gdc_bus_t busS1_nxt, busS2_nxt, busS3_nxt;
    logic     wrRise;

    // a change counts only once stages two and three agree
    always_comb begin
        wrS1_nxt    = writeStrobeN;
        wrS2_nxt    = wrS1_r;
        wrS3_nxt    = wrS2_r;
        busS1_nxt   = hostBus;
        busS2_nxt   = busS1_r;
        busS3_nxt   = busS2_r;
        wrLevel_nxt = (wrS2_r == wrS3_r) ? wrS3_r : wrLevel_r;
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wrS1_r    <= STROBE_IDLE_RST;
            wrS2_r    <= STROBE_IDLE_RST;
            wrS3_r    <= STROBE_IDLE_RST;
            wrLevel_r <= STROBE_IDLE_RST;
            busS1_r   <= '0;
            busS2_r   <= '0;
            busS3_r   <= '0;
        end else begin
            wrS1_r    <= wrS1_nxt;
            wrS2_r    <= wrS2_nxt;
            wrS3_r    <= wrS3_nxt;
            wrLevel_r <= wrLevel_nxt;
            busS1_r   <= busS1_nxt;
            busS2_r   <= busS2_nxt;
            busS3_r   <= busS3_nxt;
        end
    end

    // rising write strobe, one cycle
    assign wrRise = !wrLevel_r && wrLevel_nxt;

    // ------------------------------------------------------------------
    // cycle classification
    // ------------------------------------------------------------------
    logic       cmdWrite;
    logic       paramWrite;
    logic [7:0] lowByte;

    // upper byte is never looked at
    assign lowByte    = busS3_r.data[PARAM_MSB:PARAM_LSB];
    assign cmdWrite   = wrRise && !busS3_r.dataCommandSelect;
    assign paramWrite = wrRise && busS3_r.dataCommandSelect && busS3_r.readStrobeN;

    // one-hot decode, also used to judge validity
    function automatic logic [2:0] curve_decode(input logic [7:0] code);
        case (code)
            CURVE1_BIT: curve_decode = 3'b100;
            CURVE2_BIT: curve_decode = 3'b101;
            CURVE3_BIT: curve_decode = 3'b110;
            CURVE4_BIT: curve_decode = 3'b111;
            default:    curve_decode = 3'b000;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // command state and stored settings
    // ------------------------------------------------------------------
    gdc_state_t state_r, state_nxt;
    logic [7:0] curveCode_r, curveCode_nxt;
    logic       dispReq_r, dispReq_nxt;
    logic       display_output_enable_cmd_r, display_output_enable_cmd_nxt;
    logic [2:0] paramDec;

    assign paramDec = curve_decode(lowByte);

    // no operating-mode input gates any of this: all commands always accepted
    always_comb begin
        state_nxt     = state_r;
        curveCode_nxt = curveCode_r;
        dispReq_nxt   = dispReq_r;
        display_output_enable_cmd_nxt    = display_output_enable_cmd_r;
        if (cmdWrite) begin
            // any command other than 26h drops a pending parameter; a repeat 26h keeps waiting
            state_nxt = GDC_IDLE;
            case (busS3_r.data[PARAM_MSB:PARAM_LSB])
                GAMMA_CURVE_SELECT_CMD: begin
                    state_nxt = GDC_WAIT_PARAM;
                end
                DISPLAY_OUTPUT_DISABLE_CMD: begin
                    dispReq_nxt = 1'b0;
                end
                DISPLAY_OUTPUT_ENABLE_CMD: begin
                    dispReq_nxt = 1'b1;
                end
                default: begin
                    state_nxt = GDC_IDLE;
                end
            endcase
        end else if (paramWrite && state_r == GDC_WAIT_PARAM) begin
            state_nxt = GDC_IDLE;
            // invalid codes leave the active curve alone
            if (paramDec[2]) begin
                curveCode_nxt = lowByte;
            end
        end
        // panel output enable changes only at frameStart or on software reset, so display on/off never tears a frame; a new curve applies at once
        if (frameStart) begin
            display_output_enable_cmd_nxt = dispReq_r;
        end
        // software reset restores the same state and settings as a hardware reset; it does not clear the pin synchronisers
        if (softReset) begin
            state_nxt     = GDC_IDLE;
            curveCode_nxt = CURVE_SELECT_RST;
            dispReq_nxt   = DISPLAY_EN_RST;
            display_output_enable_cmd_nxt    = DISPLAY_EN_RST;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_r     <= GDC_IDLE;
            curveCode_r <= CURVE_SELECT_RST;
            dispReq_r   <= DISPLAY_EN_RST;
            display_output_enable_cmd_r    <= DISPLAY_EN_RST;
        end else begin
            state_r     <= state_nxt;
            curveCode_r <= curveCode_nxt;
            dispReq_r   <= dispReq_nxt;
            display_output_enable_cmd_r    <= display_output_enable_cmd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic [2:0] storedDec;

    // stored code is always one-hot, so the index is always defined
    assign storedDec                  = curve_decode(curveCode_r);
    assign panelCtrl.displayEnable    = display_output_enable_cmd_r;
    assign panelCtrl.curveIndex       = storedDec[1:0];
    assign panelCtrl.curveSelectParam = curveCode_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstSyncN);

    sequence s_gamma_cmd;
        cmdWrite && lowByte == GAMMA_CURVE_SELECT_CMD && !softReset;
    endsequence

    sequence s_valid_param;
        paramWrite && state_r == GDC_WAIT_PARAM && paramDec[2] && !softReset;
    endsequence

    a_gamma_cmd_arms: assert property (s_gamma_cmd |=> state_r == GDC_WAIT_PARAM)
        else $error("gamma opcode did not arm parameter wait");
    a_param_low_byte: assert property (s_valid_param |=> curveCode_r == $past(lowByte)
                                       && state_r == GDC_IDLE)
        else $error("valid parameter not loaded from low byte");
    // host model writes place 13 clocks between opcode and parameter strobe rises
    a_onehot_index: assert property (s_gamma_cmd ##[1:40] s_valid_param
                                     |=> (8'h01 << panelCtrl.curveIndex) == curveCode_r)
        else $error("curve index does not match one-hot code");
    a_one_curve: assert property ($onehot(curveCode_r) && curveCode_r[7:4] == 4'h0)
        else $error("active curve not exactly one of four");
    a_invalid_keeps: assert property (paramWrite && !paramDec[2] && !softReset |=> $stable(curveCode_r))
        else $error("invalid parameter changed the curve");
    a_soft_defaults: assert property (softReset |=> curveCode_r == CURVE_SELECT_RST
                                      && !dispReq_r && !display_output_enable_cmd_r)
        else $error("software reset did not restore defaults");
    a_off_request: assert property (cmdWrite && lowByte == DISPLAY_OUTPUT_DISABLE_CMD
                                    |=> !dispReq_r && state_r == GDC_IDLE)
        else $error("display-off not taken");
    a_on_request: assert property (cmdWrite && lowByte == DISPLAY_OUTPUT_ENABLE_CMD && !softReset
                                   |=> dispReq_r)
        else $error("display-on not taken");
    a_disp_no_side: assert property (cmdWrite && lowByte != GAMMA_CURVE_SELECT_CMD && !softReset
                                     |=> $stable(curveCode_r))
        else $error("display command changed the curve");
    a_frame_switch: assert property ($changed(display_output_enable_cmd_r) |-> $past(frameStart) || $past(softReset))
        else $error("display enable changed mid-frame");
    a_abandon_param: assert property (state_r == GDC_WAIT_PARAM && cmdWrite
                                      && lowByte != GAMMA_CURVE_SELECT_CMD
                                      |=> state_r == GDC_IDLE && $stable(curveCode_r))
        else $error("pending gamma selection not abandoned");

endmodule

// ===== verification/gdc_host_model.sv
/*
 * Host controller model: writes command and parameter words.
 * Assumes the decoder samples the bus through three-stage synchronisers.
 */
`timescale 1ns/1ps
module gdc_host_model (
    // clock
    input  wire logic              sys_clk,
    // host bus pins
    output gdc_pkg::gdc_bus_t      hostBus,
    output logic                   writeStrobeN
);
    import gdc_pkg::*;

    // idle bus: strobes high, data a fixed pattern
    initial begin
        hostBus      = '{1'b1, 1'b1, 16'hA5A5};
        writeStrobeN = 1'b1;
    end

    // ------------------------------------------------------------
    // one write cycle
    // ------------------------------------------------------------
    // strobe low and high 4+ clocks so the synchronisers see both
    task automatic put(input logic dcs, input logic rdn, input logic [15:0] word);
        @(posedge sys_clk);
        hostBus      <= '{dcs, rdn, word};
        writeStrobeN <= 1'b0;
        repeat (4) @(posedge sys_clk);
        writeStrobeN <= 1'b1; // rising edge writes
        repeat (5) @(posedge sys_clk);
        // released data no longer shows the last word
        hostBus.data <= ~word;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// ===== verification/tb_gamma_and_display_enable_cmds.sv
/*
 * Testbench for the gamma-select and display-enable decoder.
 * Assumes the host model drives the bus; frameStart comes from here.
 */
`timescale 1ns/1ps
module tb_gamma_and_display_enable_cmds;
    import gdc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic     sys_clk = 1'b0;
    logic     rstn = 1'b0;
    logic     softReset = 1'b0;
    logic     frameStart = 1'b0;
    logic     writeStrobeN;
    gdc_bus_t hostBus;
    gdc_out_t panelCtrl;
    int       err_total = 0;
    int       checked = 0;
    int       cycles = 0;

    gdc_host_model host (.sys_clk(sys_clk), .hostBus(hostBus), .writeStrobeN(writeStrobeN));
    gdc_cmd_decoder uut (.sys_clk(sys_clk), .rstn(rstn), .writeStrobeN(writeStrobeN),
        .hostBus(hostBus), .softReset(softReset), .frameStart(frameStart), .panelCtrl(panelCtrl));

    // 10 MHz clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // hang guard: whole run needs well under 3000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // step off the edge so registered outputs have settled
    task automatic chk(input gdc_out_t exp);
        #1;
        checked++;
        if (panelCtrl !== exp) begin
            err_total++;
            $display("BAD %0t out %h exp %h", $time, panelCtrl, exp);
        end
    endtask

    function automatic gdc_out_t want(input logic en, input logic [1:0] idx);
        want = '{en, idx, 8'h01 << idx};
    endfunction

    task automatic hw_reset();
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic frame();
        @(posedge sys_clk);
        frameStart <= 1'b1;
        @(posedge sys_clk);
        frameStart <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // every one-hot code, upper byte carrying junk
    task automatic t_curves();
        for (int i = 0; i < 4; i++) begin
            host.put(1'b0, 1'b1, 16'hFF26);
            host.put(1'b1, 1'b1, {8'hC3, 8'h01 << i});
            chk(want(1'b0, i[1:0]));
        end
    endtask

    // invalid codes, including a curve bit only in the upper byte
    task automatic t_invalid();
        logic [15:0] bad [5] = '{16'h0000, 16'h0003, 16'h0010, 16'h00FF, 16'h0100};
        foreach (bad[k]) begin
            host.put(1'b0, 1'b1, 16'h0026);
            host.put(1'b1, 1'b1, bad[k]);
            chk(want(1'b0, 2'h3));
        end
        host.put(1'b1, 1'b1, 16'h0002);
        chk(want(1'b0, 2'h3));
    endtask

    // read strobe low keeps the wait; a new command abandons it
    task automatic t_pending();
        host.put(1'b0, 1'b1, 16'h0026);
        host.put(1'b1, 1'b0, 16'h0004);
        chk(want(1'b0, 2'h3));
        host.put(1'b1, 1'b1, 16'h0002);
        chk(want(1'b0, 2'h1));
        host.put(1'b0, 1'b1, 16'h0026);
        host.put(1'b0, 1'b1, 16'h002A);
        host.put(1'b1, 1'b1, 16'h0008);
        chk(want(1'b0, 2'h1));
    endtask

    // enable changes only at a frame boundary; repeats are no-ops
    task automatic t_display();
        host.put(1'b0, 1'b1, 16'h0029);
        chk(want(1'b0, 2'h1));
        frame();
        chk(want(1'b1, 2'h1));
        host.put(1'b0, 1'b1, 16'h0029);
        frame();
        chk(want(1'b1, 2'h1));
        host.put(1'b0, 1'b1, 16'h0026);
        host.put(1'b0, 1'b1, 16'h0028);
        host.put(1'b1, 1'b1, 16'h0004);
        chk(want(1'b1, 2'h1));
        frame();
        chk(want(1'b0, 2'h1));
        host.put(1'b0, 1'b1, 16'h0028);
        frame();
        chk(want(1'b0, 2'h1));
    endtask

    // software reset drops a pending gamma select; then hardware reset
    task automatic t_resets();
        host.put(1'b0, 1'b1, 16'h0029);
        frame();
        host.put(1'b0, 1'b1, 16'h0026);
        @(posedge sys_clk);
        softReset <= 1'b1;
        @(posedge sys_clk);
        softReset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(want(1'b0, 2'h0));
        host.put(1'b1, 1'b1, 16'h0008);
        chk(want(1'b0, 2'h0));
        host.put(1'b0, 1'b1, 16'h0029);
        host.put(1'b0, 1'b1, 16'h0026);
        host.put(1'b1, 1'b1, 16'h0004);
        frame();
        chk(want(1'b1, 2'h2));
        hw_reset();
        chk(want(1'b0, 2'h0));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        hw_reset();
        chk(want(1'b0, 2'h0));
        t_curves();
        t_invalid();
        t_pending();
        t_display();
        t_resets();
        finish_test();
    end
endmodule
